//--- design/oss_pkg.sv
package oss_pkg;
  localparam int OSS_WIDTH = 8;
  localparam logic [7:0] OSS_ALL_OFF = 8'hFF;
  localparam logic [7:0] OSS_SHIFT_RESET = 8'h00;
  localparam int OSS_CLK_MHZ = 25;
  localparam int OSS_FAULT_DELAY_US = 100;
  localparam int OSS_FAULT_DELAY_CYC = OSS_FAULT_DELAY_US * OSS_CLK_MHZ;
  localparam int OSS_DLY_W = 12;
  typedef enum logic [1:0] {OSS_IDLE, OSS_FRAME} oss_state_type;
endpackage

//--- design/oss_edge_if.sv
`timescale 1ns/1ns
interface oss_edge_if;
  logic sel_fall;
  logic sel_rise;
  logic sck_fall;
  logic sck_rise;
  logic sel_low;
  modport src (output sel_fall, output sel_rise, output sck_fall, output sck_rise, output sel_low);
  modport dst (input sel_fall, input sel_rise, input sck_fall, input sck_rise, input sel_low);
endinterface

//--- design/oss_sync.sv
`timescale 1ns/1ns
module oss_sync
  import oss_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  // synchronised
  output logic si_sync,
  oss_edge_if.src edges
);
  logic [2:0] cs_meta_reg;
  logic [2:0] sck_meta_reg;
  logic [1:0] si_meta_reg;
  // ************************
  // two-stage sync; select and clock also get an edge history flop, si does not
  // ************************
  // select sync stays out of reset so reset never touches the so driver
  always_ff @(posedge mclk) begin
    cs_meta_reg <= {cs_meta_reg[1:0], cs_n};
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sck_meta_reg <= 3'h0;
      si_meta_reg <= 2'h0;
    end else begin
      sck_meta_reg <= {sck_meta_reg[1:0], sclk};
      si_meta_reg <= {si_meta_reg[0], si};
    end
  end
  assign si_sync = si_meta_reg[1];
  assign edges.sel_low = ~cs_meta_reg[1];
  assign edges.sel_fall = cs_meta_reg[2] & ~cs_meta_reg[1];
  assign edges.sel_rise = ~cs_meta_reg[2] & cs_meta_reg[1];
  assign edges.sck_fall = sck_meta_reg[2] & ~sck_meta_reg[1];
  assign edges.sck_rise = ~sck_meta_reg[2] & sck_meta_reg[1];
endmodule

//--- design/oss_core.sv
`timescale 1ns/1ns
module oss_core
  import oss_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // serial link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  output logic so_o,
  output logic so_oe,
  // power stage
  input wire logic [7:0] drain_high,
  input wire logic [7:0] short_det,
  input wire logic load_supply_ov,
  input wire logic short_protect_disable,
  output logic [7:0] out_on,
  output logic [7:0] current_limit,
  output logic open_load_en
);
  oss_edge_if edges();
  logic si_s;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] latch_reg, latch_next;
  logic [7:0] shut_reg, shut_next;
  logic [7:0] shut_keep;
  logic so_reg, so_next;
  logic ov_seen_reg;
  logic [OSS_DLY_W-1:0] dly_reg;
  logic [7:0] status_word;
  oss_state_type state_reg, state_next;

  oss_sync u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .cs_n(cs_n),
    .sclk(sclk),
    .si(si),
    .si_sync(si_s),
    .edges(edges)
  );

  // ************************
  // selection
  // ************************
  // status: high when drain high (off); overvoltage forces all ones
  assign status_word = ov_seen_reg ? OSS_ALL_OFF : drain_high;
  assign state_next = edges.sel_fall ? OSS_FRAME : (edges.sel_rise ? OSS_IDLE : state_reg);
  // capture on select fall, shift msb-first on falling clock only inside a frame
  assign shift_next = edges.sel_fall ? status_word :
                      (state_reg == OSS_FRAME && edges.sck_fall) ?
                      {shift_reg[6:0], si_s} : shift_reg;
  // so shows msb; updated on rising clock, bits beyond eight chain out
  assign so_next = edges.sel_fall ? status_word[7] :
                   (state_reg == OSS_FRAME && edges.sck_rise) ? shift_reg[7] : so_reg;
  assign latch_next = edges.sel_rise ? shift_reg : latch_reg;
  // protect disabled: keep on and limit; else latch the affected output off until next update
  // set wins: a short present at the update edge relatches at once, no glitch on
  assign shut_keep = edges.sel_rise ? 8'h00 : shut_reg;
  assign shut_next = short_protect_disable ? shut_keep : (shut_keep | short_det);
  assign out_on = ~latch_reg & ~shut_reg & {8{~load_supply_ov}};
  assign current_limit = short_det & out_on & {8{short_protect_disable}};
  assign open_load_en = (dly_reg == '0);
  assign so_oe = edges.sel_low;
  assign so_o = so_reg;

  // ************************
  // registers loaded by reset: latch to all ones (all off), the others cleared
  // ************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= OSS_SHIFT_RESET;
      latch_reg <= OSS_ALL_OFF;
      shut_reg <= 8'h00;
      state_reg <= OSS_IDLE;
    end else begin
      shift_reg <= shift_next;
      latch_reg <= latch_next;
      shut_reg <= shut_next;
      state_reg <= state_next;
    end
  end

  // ************************
  // serial out data: reset-independent
  // ************************
  always_ff @(posedge mclk) begin
    so_reg <= so_next;
  end

  // ************************
  // overvoltage flag and fault delay
  // ************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ov_seen_reg <= 1'b0;
      dly_reg <= '0;
    end else begin
      // set wins: a new overvoltage overrides clearing after report
      if (load_supply_ov) begin
        ov_seen_reg <= 1'b1;
      end else if (edges.sel_rise) begin
        ov_seen_reg <= 1'b0;
      end
      if (edges.sel_rise) begin
        dly_reg <= OSS_DLY_W'(OSS_FAULT_DELAY_CYC);
      end else if (dly_reg != '0) begin
        dly_reg <= dly_reg - 1'b1;
      end
    end
  end
endmodule

//--- tb/oss_core_chk.sv
`timescale 1ns/1ns
module oss_core_chk (
  input wire logic mclk, rst_n, cs_n, sclk, so_o, so_oe, load_supply_ov, short_protect_disable, open_load_en,
  input wire logic [7:0] short_det, out_on
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // quiet start of a frame, before the first shift clock
  sequence s_quiet; (!sclk && !cs_n) [*6]; endsequence
  a_idle_float: assert property (cs_n [*5] |-> !so_oe) else $error("so on");
  a_sel_drive: assert property (!cs_n [*5] |-> so_oe) else $error("so off");
  a_latch_hold: assert property ((cs_n && short_det == 8'h00 && !load_supply_ov) [*8] |-> $stable(out_on))
    else $error("out moved");
  a_so_steady: assert property (s_quiet |-> $stable(so_o)) else $error("so moved");
  a_ov_off: assert property (load_supply_ov |-> ##[0:2] out_on == 8'h00) else $error("ov on");
  a_reset_off: assert property (disable iff (1'b0) !rst_n |-> out_on == 8'h00) else $error("rst on");
  a_load_delay: assert property ($rose(cs_n) |-> ##5 !open_load_en) else $error("early");
  a_short_off: assert property ((out_on & short_det) != 8'h00 && !short_protect_disable ##1 $stable(short_det)
    |-> ##1 (out_on & short_det) == 8'h00) else $error("short on");
endmodule
bind oss_core oss_core_chk oss_core_chk_i (.*);

//--- tb/oss_master.sv
`timescale 1ns/1ns
module oss_master (
  output logic cs_n = 1'b1, sclk = 1'b0, si = 1'b0,
  input wire logic so_o,
  input wire logic so_oe
);
  logic so_line;
  // a released line shows the inverse, so a read outside the driven window is caught
  assign so_line = so_oe ? so_o : ~so_o;
  // so read at each falling edge, after the device moved it on the rise
  task automatic xfer(input int n, input logic [15:0] cmd, output logic [15:0] st);
    cs_n = 1'b0;
    #160;
    for (int i = n - 1; i >= 0; i--) begin
      #80 si = cmd[i];
      #80 sclk = 1'b1;
      #160 st[i] = so_line;
      sclk = 1'b0;
    end
    #160 cs_n = 1'b1;
    si = ~si;
    #320;
  endtask
endmodule

//--- tb/tb_oss_core.sv
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module tb_oss_core import oss_pkg::*; ();
  struct packed {logic [7:0] cmd, drn, sht; logic spd;} rows [4] = '{'{8'hA5, 8'h3C, 8'h00, 1'b0},
    '{8'h00, 8'hFF, 8'h01, 1'b0}, '{8'h0F, 8'h00, 8'h80, 1'b1}, '{8'hFF, 8'h5A, 8'h00, 1'b0}};
  logic mclk = 1'b0, rst_n = 1'b1, load_supply_ov = 1'b0, short_protect_disable = 1'b0;
  logic cs_n, sclk, si, so_o, so_oe, open_load_en;
  logic [7:0] drain_high = 8'h00, short_det = 8'h00, out_on, current_limit;
  logic [15:0] st;
  int err_count = 0, check_count = 0, cyc = 0;
  oss_core oss_core_i (.*);
  oss_master oss_master_i (.cs_n, .sclk, .si, .so_o, .so_oe);
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk) if (++cyc == 20000) begin
    err_count++;
    complete_run();
  end
  task automatic complete_run();
    $display("checks %0d errs %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #2 rst_n = 1'b0;
    repeat (10) @(posedge mclk);
    #2 rst_n = 1'b1;
    repeat (4) @(posedge mclk);
    #2;
    foreach (rows[i]) begin
      drain_high = rows[i].drn;
      short_det = rows[i].sht;
      short_protect_disable = rows[i].spd;
      oss_master_i.xfer(8, {8'h00, rows[i].cmd}, st);
      `CHK(st[7:0], rows[i].drn)
      `CHK(out_on, ~rows[i].cmd & ~(rows[i].sht & {8{~rows[i].spd}}))
      `CHK(current_limit, rows[i].sht & ~rows[i].cmd & {8{rows[i].spd}})
      $display("row %0d done", i);
    end
    oss_master_i.xfer(16, 16'h3CC3, st);
    `CHK(st, 16'h5A3C)
    `CHK(out_on, 8'h3C)
    `CHK(open_load_en, 1'b0)
    repeat (OSS_FAULT_DELAY_CYC) @(posedge mclk);
    #2 `CHK(open_load_en, 1'b1)
    $display("chain done");
    load_supply_ov = 1'b1;
    repeat (3) @(posedge mclk);
    #2 `CHK(out_on, 8'h00)
    load_supply_ov = 1'b0;
    oss_master_i.xfer(8, 16'h0000, st);
    `CHK(st[7:0], OSS_ALL_OFF)
    short_det = 8'h10;
    repeat (3) @(posedge mclk);
    #2 `CHK(out_on, 8'hEF)
    short_det = 8'h00;
    repeat (3) @(posedge mclk);
    #2 `CHK(out_on, 8'hEF)
    rst_n = 1'b0;
    repeat (7) @(posedge mclk);
    #2 `CHK(out_on, 8'h00)
    rst_n = 1'b1;
    repeat (4) @(posedge mclk);
    #2;
    oss_master_i.xfer(8, 16'h0055, st);
    `CHK(st[7:0], 8'h5A)
    `CHK(out_on, 8'hAA)
    $display("fault done");
    complete_run();
  end
endmodule
